/* File: design/cia_defs.svh */
`ifndef CIA_DEFS_SVH
`define CIA_DEFS_SVH

// register offsets
`define CIA_ADDR_BUF_PD    8'h0B
`define CIA_ADDR_MON_CFG   8'h13
`define CIA_ADDR_PIN_ROUTE 8'h14
`define CIA_ADDR_SEL_ROUTE 8'h15

// reset values
`define CIA_RST_BUF_PD     8'h40
`define CIA_RST_MON_CFG    8'h2C
`define CIA_RST_PIN_ROUTE  8'h3C
`define CIA_RST_SEL_ROUTE  8'hFF

// host-writable bits
`define CIA_WMASK_BUF_PD    8'h0F
`define CIA_WMASK_MON_CFG   8'hFF
`define CIA_WMASK_PIN_ROUTE 8'h3F
`define CIA_WMASK_SEL_ROUTE 8'h1F

// monitor configuration fields
`define CIA_MON_OFFSET_MONITOR_GLOBAL_ENABLE     7
`define CIA_MON_THR_HI     6
`define CIA_MON_THR_LO     5
`define CIA_MON_VAL_HI     4
`define CIA_MON_VAL_LO     3
`define CIA_MON_LOCK_HI    2
`define CIA_MON_LOCK_LO    0

// pin routing fields
`define CIA_RT_INT         0
`define CIA_RT_LOL         1
`define CIA_RT_FAULT_LO    2
`define CIA_RT_FAULT_HI    4
`define CIA_RT_ALARM       5

// select routing fields
`define CIA_SEL_SRC        0
`define CIA_SEL_ACT_LO     1
`define CIA_SEL_ACT_HI     4

// timing
`define CIA_CLK_MHZ        20
`define CIA_VAL_T0_US      2000
`define CIA_VAL_T1_US      100000
`define CIA_VAL_T2_US      200000
`define CIA_VAL_T3_US      13000000
`define CIA_LOCK_T0_US     106000
`define CIA_LOCK_T1_US     53000
`define CIA_LOCK_T2_US     26500
`define CIA_LOCK_T3_US     13300
`define CIA_LOCK_T4_US     6600
`define CIA_LOCK_T5_US     3300
`define CIA_LOCK_T6_US     1660
`define CIA_LOCK_T7_US     833

`endif

/* File: design/cia_pkg.sv */
package cia_pkg;

  typedef logic [28:0] cia_vcnt_t;
  typedef logic [21:0] cia_lcnt_t;

  // register access from the serial configuration front end
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } cia_req_t;

  // raw status entering from pins or other clock domains
  typedef struct packed {
    logic [3:0] alarm_raw;
    logic       phase_slip;
    logic [1:0] sel_pins;
  } cia_async_t;

  // one tristatable output group
  typedef struct packed {
    logic [3:0] act_o;
    logic [3:0] act_oe;
    logic [2:0] fault_o;
    logic [2:0] fault_oe;
    logic       lol_o;
    logic       lol_oe;
    logic       int_alm_o;
    logic       int_alm_oe;
  } cia_pins_t;

  typedef struct packed {
    logic [7:0]           buf_pd_r;
    logic [7:0]           mon_cfg_r;
    logic [7:0]           pin_route_r;
    logic [7:0]           sel_route_r;
    cia_async_t           s1_r;
    cia_async_t           s2_r;
    cia_async_t           s3_r;
    cia_async_t           filt_r;
    logic                 slip_prev_r;
    logic [3:0]           alarm_hold_r;
    logic [3:0][28:0]     valid_cnt_r;
    cia_lcnt_t            lock_cnt_r;
    logic                 lock_loss_r;
    logic [7:0]           rdata_r;
    logic                 rvalid_r;
    logic [3:0]           buf_off_r;
    logic [3:0]           offset_monitor_global_enable_r;
    logic [1:0]           thr_r;
    logic [1:0]           msel_r;
    logic [3:0]           alarm_out_r;
    cia_pins_t            pins_r;
  } cia_state_t;

endpackage

/* File: design/cia_regs.sv */
// Contract
// - input power-down bit 1 turns its clock input buffer off, 0 on
// - global offset enable clear disables all offset detection, else per-input enables
// - two-bit threshold field selects offset alarm level 11-12/48-49/30/200 ppm
// - input alarm stays until clock valid for 2 ms, 100 ms, 200 ms, 13 s
// - retrigger field sets lock one-shot interval 106 ms down to 833 us
// - every phase slip retriggers the lock-monitoring one-shot; the filter passes only a slip held for two or more clocks
// - alarm route bit puts combined alarm on shared pin when interrupt route is 0
// - interrupt route 1 puts interrupt on shared pin, combined alarm on no pin
// - both interrupt and alarm route 0 tristate the shared pin
// - fault route bits 2..4 drive input fault status on its pin, else tristate
// - lock-loss route bit 1 drives lock-loss status on its pin, else tristate
// - reset loads 0x2C monitor config, 0x3C pin routing, 0xFF select routing
// - reset loads 0x40 into input power-down, all buffers enabled
// - select source bit 1 picks external select pins, 0 the internal field
// - active route bits drive active status or tristate, only when source bit is 1
`include "cia_defs.svh"

module cia_regs
#(
  parameter cia_pkg::cia_vcnt_t VAL_CYC0 = 29'(`CIA_VAL_T0_US * `CIA_CLK_MHZ),
  parameter cia_pkg::cia_vcnt_t VAL_CYC1 = 29'(`CIA_VAL_T1_US * `CIA_CLK_MHZ),
  parameter cia_pkg::cia_vcnt_t VAL_CYC2 = 29'(`CIA_VAL_T2_US * `CIA_CLK_MHZ),
  parameter cia_pkg::cia_vcnt_t VAL_CYC3 = 29'(`CIA_VAL_T3_US * `CIA_CLK_MHZ),
  parameter logic [7:0][21:0]   LOCK_CYC =
  {
    22'(`CIA_LOCK_T7_US * `CIA_CLK_MHZ),
    22'(`CIA_LOCK_T6_US * `CIA_CLK_MHZ),
    22'(`CIA_LOCK_T5_US * `CIA_CLK_MHZ),
    22'(`CIA_LOCK_T4_US * `CIA_CLK_MHZ),
    22'(`CIA_LOCK_T3_US * `CIA_CLK_MHZ),
    22'(`CIA_LOCK_T2_US * `CIA_CLK_MHZ),
    22'(`CIA_LOCK_T1_US * `CIA_CLK_MHZ),
    22'(`CIA_LOCK_T0_US * `CIA_CLK_MHZ)
  }
)
(
  // clock, reset, enable
  input  wire logic                CLK,
  input  wire logic                RST_B,
  input  wire logic                CE,
  // register access
  input  wire cia_pkg::cia_req_t   REG_REQ,
  output      logic [7:0]          REG_RDATA,
  output      logic                REG_RVALID,
  // asynchronous status and pins
  input  wire cia_pkg::cia_async_t ASYNC_IN,
  // same-clock status
  input  wire logic [3:0]          OFFSET_MONITOR_PER_INPUT_ENABLE,
  input  wire logic [3:0]          INPUT_ACTIVE,
  input  wire logic                INTERRUPT_STATUS,
  input  wire logic [1:0]          INTERNAL_SELECT_FIELD,
  // controls to the clock path
  output      logic [3:0]          INPUT_BUFFER_OFF,
  output      logic [3:0]          OFFSET_DETECT_ENABLE,
  output      logic [1:0]          OFFSET_THRESHOLD_SELECT,
  output      logic [1:0]          MANUAL_SELECT,
  output      logic [3:0]          INPUT_ALARM,
  output      logic                LOCK_LOSS_STATUS,
  // status pins
  output      cia_pkg::cia_pins_t  PINS
);
  import cia_pkg::*;

  cia_state_t st_r;
  cia_state_t st_nxt;

  localparam cia_state_t ST_RST = '{
    buf_pd_r:    `CIA_RST_BUF_PD,
    mon_cfg_r:   `CIA_RST_MON_CFG,
    pin_route_r: `CIA_RST_PIN_ROUTE,
    sel_route_r: `CIA_RST_SEL_ROUTE,
    default:     '0
  };

  // merge a host write; reserved bits keep their stored reset value
  function automatic logic [7:0] wr_merge(input logic [7:0] old_v,
                                          input logic [7:0] wd,
                                          input logic [7:0] wmask);
    wr_merge = (old_v & ~wmask) | (wd & wmask);
  endfunction

  function automatic cia_vcnt_t val_limit(input logic [1:0] code);
    unique case (code)
      2'h0:
      begin
        val_limit = VAL_CYC0;
      end
      2'h1:
      begin
        val_limit = VAL_CYC1;
      end
      2'h2:
      begin
        val_limit = VAL_CYC2;
      end
      2'h3:
      begin
        val_limit = VAL_CYC3;
      end
    endcase
  endfunction

  logic [1:0] val_code;
  logic [2:0] lock_code;
  logic       slip_edge;
  logic       comb_alarm;
  cia_vcnt_t  val_lim;

  assign val_code  = st_r.mon_cfg_r[`CIA_MON_VAL_HI:`CIA_MON_VAL_LO];
  assign lock_code = st_r.mon_cfg_r[`CIA_MON_LOCK_HI:`CIA_MON_LOCK_LO];
  assign val_lim   = val_limit(val_code);
  // only the filtered copy is edge-detected, never the raw synchroniser
  assign slip_edge = st_r.filt_r.phase_slip & ~st_r.slip_prev_r;
  assign comb_alarm = |st_r.alarm_hold_r;

  always_comb
  begin
    st_nxt = st_r;

    // host register access
    if (REG_REQ.we)
    begin
      unique case (REG_REQ.addr)
        `CIA_ADDR_BUF_PD:
        begin
          st_nxt.buf_pd_r = wr_merge(st_r.buf_pd_r, REG_REQ.wdata,
                                     `CIA_WMASK_BUF_PD);
        end
        `CIA_ADDR_MON_CFG:
        begin
          st_nxt.mon_cfg_r = wr_merge(st_r.mon_cfg_r, REG_REQ.wdata,
                                      `CIA_WMASK_MON_CFG);
        end
        `CIA_ADDR_PIN_ROUTE:
        begin
          st_nxt.pin_route_r = wr_merge(st_r.pin_route_r, REG_REQ.wdata,
                                        `CIA_WMASK_PIN_ROUTE);
        end
        `CIA_ADDR_SEL_ROUTE:
        begin
          st_nxt.sel_route_r = wr_merge(st_r.sel_route_r, REG_REQ.wdata,
                                        `CIA_WMASK_SEL_ROUTE);
        end
        default:
        begin
          // unmapped writes are dropped silently
        end
      endcase
    end

    // every read is answered one edge later, mapped or not
    st_nxt.rvalid_r = REG_REQ.re;
    if (REG_REQ.re)
    begin
      unique case (REG_REQ.addr)
        `CIA_ADDR_BUF_PD:
        begin
          st_nxt.rdata_r = st_r.buf_pd_r;
        end
        `CIA_ADDR_MON_CFG:
        begin
          st_nxt.rdata_r = st_r.mon_cfg_r;
        end
        `CIA_ADDR_PIN_ROUTE:
        begin
          st_nxt.rdata_r = st_r.pin_route_r;
        end
        `CIA_ADDR_SEL_ROUTE:
        begin
          st_nxt.rdata_r = st_r.sel_route_r;
        end
        default:
        begin
          // unmapped reads answer zero
          st_nxt.rdata_r = 8'h00;
        end
      endcase
    end

    // three-stage synchroniser, a rise taken once stages two and three agree, a fall as soon as they differ
    st_nxt.s1_r = ASYNC_IN;
    st_nxt.s2_r = st_r.s1_r;
    st_nxt.s3_r = st_r.s2_r;
    st_nxt.filt_r = (st_r.filt_r & ~(st_r.s2_r ^ st_r.s3_r))
                  | (st_r.s3_r & ~(st_r.s2_r ^ st_r.s3_r));
    st_nxt.slip_prev_r = st_r.filt_r.phase_slip;

    // alarm held until the clock has been good for the chosen time
    for (int i = 0; i < 4; i++)
    begin
      if (st_r.filt_r.alarm_raw[i])
      begin
        st_nxt.alarm_hold_r[i] = 1'b1;
        st_nxt.valid_cnt_r[i]  = '0;
      end
      else if (st_r.alarm_hold_r[i])
      begin
        if (st_r.valid_cnt_r[i] + 29'h1 >= val_lim)
        begin
          st_nxt.alarm_hold_r[i] = 1'b0;
          st_nxt.valid_cnt_r[i]  = '0;
        end
        else
        begin
          st_nxt.valid_cnt_r[i] = st_r.valid_cnt_r[i] + 29'h1;
        end
      end
    end

    // lock one-shot: a slip reloads the full interval, even mid-count
    if (slip_edge)
    begin
      st_nxt.lock_cnt_r  = LOCK_CYC[lock_code];
      st_nxt.lock_loss_r = 1'b1;
    end
    else if (st_r.lock_cnt_r != '0)
    begin
      st_nxt.lock_cnt_r = st_r.lock_cnt_r - 22'h1;
      if (st_r.lock_cnt_r == 22'h1)
      begin
        st_nxt.lock_loss_r = 1'b0;
      end
    end

    // controls toward the clock path
    st_nxt.buf_off_r = st_r.buf_pd_r[3:0];
    st_nxt.offset_monitor_global_enable_r  = {4{st_r.mon_cfg_r[`CIA_MON_OFFSET_MONITOR_GLOBAL_ENABLE]}}
                     & OFFSET_MONITOR_PER_INPUT_ENABLE;
    st_nxt.thr_r     = st_r.mon_cfg_r[`CIA_MON_THR_HI:`CIA_MON_THR_LO];
    st_nxt.msel_r    = st_r.sel_route_r[`CIA_SEL_SRC] ? st_r.filt_r.sel_pins
                                                      : INTERNAL_SELECT_FIELD;
    st_nxt.alarm_out_r = st_r.alarm_hold_r;

    // shared interrupt / alarm pin, interrupt routing has priority
    if (st_r.pin_route_r[`CIA_RT_INT])
    begin
      st_nxt.pins_r.int_alm_o  = INTERRUPT_STATUS;
      st_nxt.pins_r.int_alm_oe = 1'b1;
    end
    else if (st_r.pin_route_r[`CIA_RT_ALARM])
    begin
      st_nxt.pins_r.int_alm_o  = comb_alarm;
      st_nxt.pins_r.int_alm_oe = 1'b1;
    end
    else
    begin
      st_nxt.pins_r.int_alm_o  = 1'b0;
      st_nxt.pins_r.int_alm_oe = 1'b0;
    end

    for (int i = 0; i < 3; i++)
    begin
      st_nxt.pins_r.fault_oe[i] = st_r.pin_route_r[`CIA_RT_FAULT_LO + i];
      st_nxt.pins_r.fault_o[i]  = st_r.alarm_hold_r[i]
                                & st_r.pin_route_r[`CIA_RT_FAULT_LO + i];
    end

    // a pin off the bus drives 0 so nothing toggles behind a disabled buffer
    if (st_r.pin_route_r[`CIA_RT_LOL])
    begin
      st_nxt.pins_r.lol_o  = st_r.lock_loss_r;
      st_nxt.pins_r.lol_oe = 1'b1;
    end
    else
    begin
      st_nxt.pins_r.lol_o  = 1'b0;
      st_nxt.pins_r.lol_oe = 1'b0;
    end

    // active pins exist only while the external select pins are in use
    for (int i = 0; i < 4; i++)
    begin
      st_nxt.pins_r.act_oe[i] = st_r.sel_route_r[`CIA_SEL_ACT_LO + i]
                              & st_r.sel_route_r[`CIA_SEL_SRC];
      st_nxt.pins_r.act_o[i]  = INPUT_ACTIVE[i] & st_nxt.pins_r.act_oe[i];
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_r <= ST_RST;
    end
    else if (CE)
    begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA               = st_r.rdata_r;
  assign REG_RVALID              = st_r.rvalid_r;
  assign INPUT_BUFFER_OFF        = st_r.buf_off_r;
  assign OFFSET_DETECT_ENABLE    = st_r.offset_monitor_global_enable_r;
  assign OFFSET_THRESHOLD_SELECT = st_r.thr_r;
  assign MANUAL_SELECT           = st_r.msel_r;
  assign INPUT_ALARM             = st_r.alarm_out_r;
  assign LOCK_LOSS_STATUS        = st_r.lock_loss_r;
  assign PINS                    = st_r.pins_r;

endmodule

/* File: tb/cia_regs_monitor.sv */
module cia_regs_monitor
(
  // clock and reset
  input wire logic                 CLK,
  input wire logic                 RST_B,
  // register access
  input wire cia_pkg::cia_req_t    REG_REQ,
  input wire logic [7:0]           REG_RDATA,
  input wire logic                 REG_RVALID,
  // status and controls
  input wire cia_pkg::cia_async_t  ASYNC_IN,
  input wire logic [3:0]           OFFSET_MONITOR_PER_INPUT_ENABLE,
  input wire logic [3:0]           INPUT_BUFFER_OFF,
  input wire logic [3:0]           OFFSET_DETECT_ENABLE,
  input wire logic [1:0]           OFFSET_THRESHOLD_SELECT,
  input wire logic [3:0]           INPUT_ALARM,
  input wire logic                 LOCK_LOSS_STATUS,
  input wire cia_pkg::cia_pins_t   PINS
);
  timeunit 1ns;
  timeprecision 1ns;
  import cia_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // a lone write, so the output two edges on reflects only this one
  sequence s_wr(logic [7:0] a);
    REG_REQ.we && REG_REQ.addr == a ##1 !(REG_REQ.we && REG_REQ.addr == a);
  endsequence
  a_read_pulse: assert property (REG_REQ.re |=> REG_RVALID)
    else $error("read gave no valid");
  a_no_stray: assert property (!REG_REQ.re |=> !REG_RVALID)
    else $error("valid without read");
  a_unmapped_zero: assert property (REG_REQ.re && !(REG_REQ.addr inside
    {8'h0B, 8'h13, 8'h14, 8'h15}) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_buf_follow: assert property (s_wr(8'h0B) |=>
    INPUT_BUFFER_OFF == $past(REG_REQ.wdata[3:0], 2))
    else $error("buffer off wrong");
  a_thr_follow: assert property (s_wr(8'h13) |=>
    OFFSET_THRESHOLD_SELECT == $past(REG_REQ.wdata[6:5], 2))
    else $error("threshold wrong");
  a_global_gate: assert property (s_wr(8'h13) |=> OFFSET_DETECT_ENABLE ==
    ($past(REG_REQ.wdata[7], 2) ? $past(OFFSET_MONITOR_PER_INPUT_ENABLE) : 4'h0))
    else $error("offset enable wrong");
  a_pin_gate: assert property ((PINS.fault_o & ~PINS.fault_oe) == 3'h0 &&
    (PINS.act_o & ~PINS.act_oe) == 4'h0 && !(PINS.lol_o && !PINS.lol_oe) &&
    !(PINS.int_alm_o && !PINS.int_alm_oe))
    else $error("pin driven while off");
  a_alarm_rise: assert property ($rose(ASYNC_IN.alarm_raw[0]) |-> ##[1:8] INPUT_ALARM[0])
    else $error("alarm not raised");
  a_slip_rise: assert property ($rose(ASYNC_IN.phase_slip) |-> ##[1:8] LOCK_LOSS_STATUS)
    else $error("slip not seen");
  c_int_route: cover property (PINS.int_alm_oe && PINS.int_alm_o);
  c_lock_drop: cover property ($fell(LOCK_LOSS_STATUS));
  c_alarm_drop: cover property ($fell(INPUT_ALARM[0]));
endmodule

bind cia_regs cia_regs_monitor mon
(
  .CLK, .RST_B, .REG_REQ, .REG_RDATA, .REG_RVALID, .ASYNC_IN,
  .OFFSET_MONITOR_PER_INPUT_ENABLE, .INPUT_BUFFER_OFF, .OFFSET_DETECT_ENABLE,
  .OFFSET_THRESHOLD_SELECT, .INPUT_ALARM, .LOCK_LOSS_STATUS, .PINS
);

/* File: tb/cia_host.sv */
module cia_host
(
  // bus clock
  input  wire logic              CLK,
  // register access
  output      cia_pkg::cia_req_t REG_REQ,
  input  wire logic [7:0]        REG_RDATA,
  input  wire logic              REG_RVALID
);
  timeunit 1ns;
  timeprecision 1ns;
  import cia_pkg::*;
  initial REG_REQ = '0;
  // strobe spans one sampling edge, address and data held across it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_REQ <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge CLK);
    REG_REQ.we <= 1'b0;
  endtask
  // valid stands one cycle only, so data is taken at that very edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    REG_REQ <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge CLK);
    REG_REQ.re <= 1'b0;
    @(posedge CLK);
    d = (REG_RVALID === 1'b1) ? REG_RDATA : 8'hXX;
  endtask
endmodule

/* File: tb/cia_regs_tb.sv */
module cia_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cia_pkg::*;
  logic       clk, rst_b, ce, intst, lls;
  logic       rvalid;
  logic [7:0] rdata, v;
  logic [3:0] fen, act, boff, den, alm;
  logic [1:0] isel, thr, msel;
  cia_req_t   req;
  cia_async_t ain;
  cia_pins_t  pins;
  int         errors, checks;
  logic [7:0] ra[5] = '{8'h0B, 8'h13, 8'h14, 8'h15, 8'h20};
  logic [7:0] rv[5] = '{8'h40, 8'h2C, 8'h3C, 8'hFF, 8'h00};
  logic [7:0] wd[5] = '{8'hFF, 8'hA5, 8'hFF, 8'h00, 8'hFF};
  logic [7:0] wx[5] = '{8'h4F, 8'hA5, 8'h3F, 8'hE0, 8'h00};
  logic [7:0] pr[5] = '{8'h01, 8'h21, 8'h20, 8'h00, 8'h1C};
  logic [7:0] px[5] = '{8'h80, 8'h80, 8'hC0, 8'h00, 8'h3D};

  cia_host host (.CLK(clk), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid));
  // short counts keep the run brief; lock code c lasts 80 - 10c cycles
  cia_regs #(.VAL_CYC0(29'd8), .VAL_CYC1(29'd16), .VAL_CYC2(29'd24), .VAL_CYC3(29'd32),
    .LOCK_CYC({22'd10, 22'd20, 22'd30, 22'd40, 22'd50, 22'd60, 22'd70, 22'd80})) dut
  (
    .CLK(clk), .RST_B(rst_b), .CE(ce), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .ASYNC_IN(ain), .OFFSET_MONITOR_PER_INPUT_ENABLE(fen),
    .INPUT_ACTIVE(act), .INTERRUPT_STATUS(intst), .INTERNAL_SELECT_FIELD(isel),
    .INPUT_BUFFER_OFF(boff), .OFFSET_DETECT_ENABLE(den), .OFFSET_THRESHOLD_SELECT(thr),
    .MANUAL_SELECT(msel), .INPUT_ALARM(alm), .LOCK_LOSS_STATUS(lls), .PINS(pins)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic test_done;
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    cyc(20000);
    errors++;
    test_done;
  end

  initial
  begin
    {rst_b, intst, fen, act, isel, ain} = '0;
    ce = 1'b1;
    cyc(20);
    rst_b <= 1'b1;
    foreach (ra[i])
    begin
      host.rd(ra[i], v);
      chk("reset", v, rv[i]);
    end
    foreach (ra[i])
    begin
      host.wr(ra[i], wd[i]);
      host.rd(ra[i], v);
      chk("readback", v, wx[i]);
    end
    chk("buf_off", {4'h0, boff}, 8'h0F);
    host.wr(8'h0B, 8'h05);
    cyc(2);
    chk("buf_off", {4'h0, boff}, 8'h05);
    fen <= 4'h9;
    for (int c = 0; c < 4; c++)
    begin
      host.wr(8'h13, {c[0], c[1:0], 5'h00});
      cyc(2);
      chk("thr", {6'h0, thr}, 8'(c));
      chk("det_en", {4'h0, den}, c[0] ? 8'h09 : 8'h00);
    end
    // alarm raised, interrupt low: shared pin tells the two sources apart
    ain.alarm_raw <= 4'b0101;
    cyc(10);
    foreach (pr[i])
    begin
      host.wr(8'h14, pr[i]);
      cyc(2);
      chk("pins", {pins.int_alm_oe, pins.int_alm_o, pins.fault_oe, pins.fault_o},
        px[i]);
    end
    intst <= 1'b1;
    host.wr(8'h14, 8'h21);
    cyc(2);
    chk("int_pin", {pins.int_alm_oe, pins.int_alm_o, pins.fault_oe, pins.fault_o},
      8'hC0);
    intst <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      host.wr(8'h13, {3'h0, k[1:0], 3'h0});
      ain.alarm_raw <= 4'h0;
      cyc(8 * (k + 1));
      chk("alarm_hold", {7'h0, alm[0]}, 8'h01);
      cyc(10);
      chk("alarm_clear", {7'h0, alm[0]}, 8'h00);
      ain.alarm_raw <= 4'h1;
      cyc(10);
    end
    host.wr(8'h14, 8'h02);
    for (int c = 0; c < 8; c++)
    begin
      host.wr(8'h13, 8'(c));
      ain.phase_slip <= 1'b1;
      cyc(6);
      ain.phase_slip <= 1'b0;
      cyc(74 - 10 * c);
      chk("lock_on", {6'h0, pins.lol_oe, lls}, 8'h03);
      chk("lock_loss_route", {7'h0, pins.lol_o}, 8'h01);
      cyc(12);
      chk("lock_off", {6'h0, pins.lol_oe, lls}, 8'h02);
    end
    ain.sel_pins <= 2'b10;
    isel <= 2'b01;
    act <= 4'hA;
    host.wr(8'h15, 8'h1F);
    cyc(8);
    chk("msel", {6'h0, msel}, 8'h02);
    chk("act", {pins.act_oe, pins.act_o}, 8'hFA);
    host.wr(8'h15, 8'h1E);
    cyc(2);
    chk("msel", {6'h0, msel}, 8'h01);
    chk("act", {pins.act_oe, pins.act_o}, 8'h00);
    test_done;
  end
endmodule
